// ===== rtl/sep_pkg.sv
// constants and types for the serial eeprom read and write-protect slave
// What this block does
// - write-protect input makes array read-only
// - protected: ack addresses, nack first data
// - read opens like write, direction bit one
// - current, random and sequential reads supported
// - address counter holds last access plus one
// - counter rolls from 255 to zero
// - ack read address, then shift byte out
// - dummy write address loads counter, read follows
// - master ack requests next byte
// - every counter bit increments in sequence
// - upper four address bits match 1010
// - reset condition aborts and refuses transfers
// - no address ack while programming
package sep_pkg;
  localparam logic [3:0] DEV_ID      = 4'hA;
  localparam int         ADDR_W      = 8;
  localparam int         DATA_W      = 8;
  localparam int         FIFO_DEPTH  = 8;
  localparam int         CLK_NS      = 20;
  localparam int         T_WR_NS     = 5_000_000;
  // longest program time rounds down
  localparam int         T_WR_CYC    = T_WR_NS / CLK_NS;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [7:0] ADDR_TOP    = 8'hFF;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sep_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_DEVADDR = 4'h1,
    ST_ACK_DEV = 4'h2,
    ST_WADDR   = 4'h3,
    ST_ACK_WA  = 4'h4,
    ST_WDATA   = 4'h5,
    ST_ACK_WD  = 4'h6,
    ST_RDATA   = 4'h7,
    ST_ACK_RD  = 4'h8,
    ST_WAIT_SP = 4'h9
  } sep_state_t;
endpackage

// ===== rtl/sep_fifo.sv
// write buffer between the serial front end and the array programmer
`timescale 1ns/1ps
`default_nettype none
module sep_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         i_clk,   // system clock
  input  wire logic         i_rst,   // async reset, high
  input  wire logic         i_flush, // drop all entries
  input  wire logic [W-1:0] i_data,  // fill data
  input  wire logic         i_valid, // fill request
  output logic              o_ready, // room for one more
  output logic [W-1:0]      o_data,  // head entry
  output logic              o_valid, // head valid
  input  wire logic         i_ready  // drain accepts head
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;

  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_ready = cnt != (AW+1)'(D);
  assign o_valid = cnt != '0;
  assign o_data  = mem[rp];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp] <= i_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else if (i_flush) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/sep_eeprom.sv
// two-wire eeprom slave: reads, byte writes, write protect
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom #(
  parameter int T_WR_CYC = sep_pkg::T_WR_CYC
) (
  input  wire logic i_clk,     // system clock, 50 MHz
  input  wire logic i_rst,     // async reset, high
  input  wire logic i_scl,     // bus clock pin
  input  wire logic i_sda,     // bus data pin level
  input  wire logic i_wp,      // write protect, high protects
  input  wire logic i_hold,    // device reset condition, high
  output logic      o_sda_out, // data pin drive value
  output logic      o_sda_oe,  // data pin pulled low when high
  output logic      o_busy     // programming cycle running
);
  logic [7:0]          mem [256];
  logic                scl_m, scl_s, scl_d;
  logic                sda_m, sda_s, sda_d;
  logic                wp_m, wp_s, hold_m, hold_s;
  sep_pkg::sep_state_t state;
  logic [7:0]          shift;
  logic [2:0]          cnt;
  logic                got8;
  logic                rw;
  logic                mack;
  logic                pending;
  logic [7:0]          addr;
  logic [31:0]         tmr;
  logic                start_ev, stop_ev, rise, fall;
  logic                load_rd, dev_hit, prog_go;
  logic [7:0]          rd_byte;
  sep_pkg::sep_wr_t    f_in, f_out;
  logic                f_push, f_ready, f_valid;

  // pins pass two flops before any use
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {wp_m, wp_s}          <= 2'h0;
      {hold_m, hold_s}      <= 2'h0;
    end else begin
      {scl_m, scl_s, scl_d} <= {i_scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {i_sda, sda_m, sda_s};
      {wp_m, wp_s}          <= {i_wp, wp_m};
      {hold_m, hold_s}      <= {i_hold, hold_m};
    end
  end

  assign start_ev = scl_s && scl_d && sda_d && !sda_s;
  assign stop_ev  = scl_s && scl_d && !sda_d && sda_s;
  assign rise     = scl_s && !scl_d;
  assign fall     = !scl_s && scl_d;
  assign rd_byte  = mem[addr];
  assign dev_hit  = (shift[7:4] == sep_pkg::DEV_ID) && !o_busy;
  assign load_rd  = fall && ((state == sep_pkg::ST_ACK_DEV && rw)
                    || (state == sep_pkg::ST_ACK_RD && mack));
  assign f_in     = '{addr: addr, data: shift};
  assign f_push   = fall && got8 && state == sep_pkg::ST_WDATA
                    && !wp_s && f_ready && !hold_s;
  assign prog_go  = stop_ev && pending && !hold_s;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state    <= sep_pkg::ST_IDLE;
      shift    <= 8'h00;
      cnt      <= 3'h0;
      got8     <= 1'b0;
      rw       <= 1'b0;
      mack     <= 1'b0;
      pending  <= 1'b0;
      addr     <= 8'h00;
      o_sda_oe <= 1'b0;
    end else if (hold_s) begin
      state    <= sep_pkg::ST_IDLE;
      o_sda_oe <= 1'b0;
      pending  <= 1'b0;
      got8     <= 1'b0;
    end else if (stop_ev) begin
      state    <= sep_pkg::ST_IDLE;
      o_sda_oe <= 1'b0;
      pending  <= 1'b0;
    end else if (start_ev) begin
      state    <= sep_pkg::ST_DEVADDR;
      o_sda_oe <= 1'b0;
      cnt      <= 3'h0;
      got8     <= 1'b0;
    end else if (load_rd) begin
      shift    <= rd_byte;
      o_sda_oe <= !rd_byte[7];
      addr     <= addr + 8'h01;
      cnt      <= 3'h0;
      state    <= sep_pkg::ST_RDATA;
    end else begin
      case (state)
        sep_pkg::ST_DEVADDR, sep_pkg::ST_WADDR, sep_pkg::ST_WDATA: begin
          if (rise) begin
            shift <= {shift[6:0], sda_s};
            cnt   <= cnt + 3'h1;
            got8  <= cnt == sep_pkg::BIT_LAST;
          end else if (fall && got8) begin
            got8 <= 1'b0;
            cnt  <= 3'h0;
            if (state == sep_pkg::ST_DEVADDR) begin
              o_sda_oe <= dev_hit;
              rw       <= shift[0];
              state    <= dev_hit ? sep_pkg::ST_ACK_DEV : sep_pkg::ST_IDLE;
            end else if (state == sep_pkg::ST_WADDR) begin
              addr     <= shift;
              o_sda_oe <= 1'b1;
              state    <= sep_pkg::ST_ACK_WA;
            end else if (f_push) begin
              addr     <= addr + 8'h01;
              pending  <= 1'b1;
              o_sda_oe <= 1'b1;
              state    <= sep_pkg::ST_ACK_WD;
            end else begin
              // protected or buffer full: withhold the acknowledge
              state <= sep_pkg::ST_WAIT_SP;
            end
          end
        end
        sep_pkg::ST_ACK_DEV, sep_pkg::ST_ACK_WA, sep_pkg::ST_ACK_WD: begin
          if (fall) begin
            o_sda_oe <= 1'b0;
            cnt      <= 3'h0;
            state    <= (state == sep_pkg::ST_ACK_DEV) ? sep_pkg::ST_WADDR
                        : sep_pkg::ST_WDATA;
          end
        end
        sep_pkg::ST_RDATA: begin
          if (fall) begin
            if (cnt == sep_pkg::BIT_LAST) begin
              o_sda_oe <= 1'b0;
              mack     <= 1'b0;
              state    <= sep_pkg::ST_ACK_RD;
            end else begin
              shift    <= {shift[6:0], 1'b0};
              o_sda_oe <= !shift[6];
              cnt      <= cnt + 3'h1;
            end
          end
        end
        sep_pkg::ST_ACK_RD: begin
          if (rise) begin
            mack <= !sda_s;
          end else if (fall) begin
            state <= sep_pkg::ST_WAIT_SP;
          end
        end
        default: begin
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // program cycle: runs its full time even if the reset condition arrives
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      tmr    <= 32'h0000_0000;
    end else if (prog_go) begin
      o_busy <= 1'b1;
      tmr    <= 32'h0000_0000;
    end else if (o_busy) begin
      if (tmr != 32'(T_WR_CYC - 1)) begin
        tmr <= tmr + 32'h0000_0001;
      end else if (!f_valid) begin
        o_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (f_valid && o_busy) begin
      mem[f_out.addr] <= f_out.data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sda_out <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
    end
  end

  sep_fifo #(
    .W ($bits(sep_pkg::sep_wr_t)),
    .D (sep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_flush (hold_s && !o_busy),
    .i_data  (f_in),
    .i_valid (f_push),
    .o_ready (f_ready),
    .o_data  (f_out),
    .o_valid (f_valid),
    .i_ready (o_busy)
  );

  // an empty buffer must stay empty across a refused data byte
  property p_wp_no_push;
    @(posedge i_clk) disable iff (i_rst)
      (wp_s && !f_valid && state == sep_pkg::ST_WDATA && fall && got8)
      |=> !f_valid && !pending;
  endproperty
  a_wp_no_push: assert property (p_wp_no_push) else $error("write while protected");

  property p_wp_nack;
    @(posedge i_clk) disable iff (i_rst)
      (state == sep_pkg::ST_WDATA && fall && got8 && wp_s && !hold_s && !start_ev && !stop_ev)
      |=> !o_sda_oe && state == sep_pkg::ST_WAIT_SP;
  endproperty
  a_wp_nack: assert property (p_wp_nack) else $error("protected data acknowledged");

  property p_dir_read;
    @(posedge i_clk) disable iff (i_rst)
      (state == sep_pkg::ST_ACK_DEV && fall && rw && !hold_s && !start_ev && !stop_ev)
      |=> state == sep_pkg::ST_RDATA;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("read direction ignored");

  property p_addr_inc;
    @(posedge i_clk) disable iff (i_rst)
      (load_rd && !hold_s && !start_ev && !stop_ev) |=> addr == $past(addr) + 8'h01;
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("counter not advanced");

  property p_wrap;
    @(posedge i_clk) disable iff (i_rst)
      (load_rd && addr == sep_pkg::ADDR_TOP && !hold_s && !start_ev && !stop_ev)
      |=> addr == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_first_bit;
    @(posedge i_clk) disable iff (i_rst)
      (load_rd && !hold_s && !start_ev && !stop_ev) |=> o_sda_oe == !$past(rd_byte[7]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("wrong first data bit");

  property p_addr_load;
    @(posedge i_clk) disable iff (i_rst)
      (state == sep_pkg::ST_WADDR && fall && got8 && !hold_s && !start_ev && !stop_ev)
      |=> addr == $past(shift) && o_sda_oe;
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("byte address not loaded");

  property p_busy_nack;
    @(posedge i_clk) disable iff (i_rst)
      (state == sep_pkg::ST_DEVADDR && fall && got8 && o_busy) |=> !o_sda_oe;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("ack while programming");

  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
      hold_s |=> state == sep_pkg::ST_IDLE && !o_sda_oe && !pending;
  endproperty
  a_hold: assert property (p_hold) else $error("transfer not aborted");

  property p_seq;
    @(posedge i_clk) disable iff (i_rst)
      (state == sep_pkg::ST_ACK_RD && fall && mack && !hold_s && !start_ev && !stop_ev)
      |=> state == sep_pkg::ST_RDATA;
  endproperty
  a_seq: assert property (p_seq) else $error("sequential read stopped");
endmodule
`default_nettype wire

// ===== testbench/sep_master.sv
// two-wire bus master model: start, stop, byte write, byte read
`timescale 1ns/1ps
`default_nettype none
module sep_master (
  input  wire logic i_clk, // system clock, paces the bus
  input  wire logic i_sda, // resolved data wire
  output logic      o_scl, // bus clock drive
  output logic      o_sda  // data drive, low pulls the wire
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // 160 ns per bit; scl rests low between bits, data moves only then
  task automatic bit_io(input logic b, output logic s);
    o_sda = b;
    tick(2);
    o_scl = 1'b1;
    tick(2);
    s = i_sda;
    tick(2);
    o_scl = 1'b0;
    tick(2);
  endtask
  // long low phase first so the slave lets go of an ack
  task automatic start();
    o_sda = 1'b1;
    tick(4);
    o_scl = 1'b1;
    tick(2);
    o_sda = 1'b0;
    tick(2);
    o_scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(2);
    o_sda = 1'b1;
    tick(4);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~more, s);
  endtask
endmodule
`default_nettype wire

// ===== testbench/sep_eeprom_tb_top.sv
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_tb_top;
  logic             i_clk = 1'b0;
  logic             i_rst = 1'b1;
  logic             i_wp = 1'b0;
  logic             i_hold = 1'b0;
  logic             scl;
  logic             m_sda;
  logic             sda;
  logic             sda_out;
  logic             sda_oe;
  logic             busy;
  logic             k;
  logic [7:0]       d;
  logic [7:0]       ref_mem [256];
  int               n_errors = 0;
  int               samples_checked = 0;
  sep_pkg::sep_wr_t rows [6] = '{'{8'h00, 8'h5A}, '{8'h01, 8'h80}, '{8'h02, 8'hC3},
                                 '{8'h7F, 8'hA5}, '{8'hFE, 8'h01}, '{8'hFF, 8'hFE}};
  // pull-up: wire low when either party pulls
  assign sda = m_sda & ~sda_oe;
  always #10 i_clk = ~i_clk;
  sep_eeprom #(.T_WR_CYC(400)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .i_wp(i_wp),
    .i_hold(i_hold), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_busy(busy));
  sep_master m (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_ack(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %b got %b", nm, exp, got);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic addr_wr(input logic [7:0] a);
    m.start();
    m.wbyte(8'hA0, k);
    chk_ack("dev ack", 1'b1, k);
    m.wbyte(a, k);
    chk_ack("addr ack", 1'b1, k);
  endtask
  // ack polling; a refused write must leave the device ready at once
  task automatic wr1(input logic [7:0] a, input logic [7:0] v, input logic ok);
    addr_wr(a);
    m.wbyte(v, k);
    chk_ack("data ack", ok, k);
    m.stop();
    repeat (8) @(negedge i_clk);
    chk_ack("busy", ok, busy);
    m.start();
    m.wbyte(8'hA0, k);
    chk_ack("busy nack", ~ok, k);
    for (int i = 0; i < 10 && !k; i++) begin
      m.stop();
      m.start();
      m.wbyte(8'hA0, k);
    end
    chk_ack("ready ack", 1'b1, k);
    m.stop();
  endtask
  task automatic rd(input logic rnd, input logic [7:0] a, input int n);
    if (rnd) addr_wr(a);
    m.start();
    m.wbyte(8'hA1, k);
    chk_ack("read ack", 1'b1, k);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, d);
      chk_byte("rd data", ref_mem[8'(a + i)], d);
    end
    m.stop();
  endtask
  initial begin
    repeat (16) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_clk);
    foreach (rows[j]) begin
      wr1(rows[j].addr, rows[j].data, 1'b1);
      ref_mem[rows[j].addr] = rows[j].data;
      rd(1'b1, rows[j].addr, 1);
    end
    rd(1'b1, 8'hFE, 3);
    rd(1'b0, 8'h01, 2);
    m.start();
    m.wbyte(8'hB0, k);
    chk_ack("bad id", 1'b0, k);
    m.stop();
    i_wp = 1'b1;
    wr1(8'h00, 8'h11, 1'b0);
    i_wp = 1'b0;
    rd(1'b1, 8'h00, 1);
    i_hold = 1'b1;
    m.start();
    m.wbyte(8'hA0, k);
    chk_ack("hold nack", 1'b0, k);
    m.stop();
    i_hold = 1'b0;
    rd(1'b1, 8'hFE, 1);
    // abort mid-read: released wire reads as all ones
    m.start();
    m.wbyte(8'hA1, k);
    chk_ack("abort ack", 1'b1, k);
    i_hold = 1'b1;
    repeat (8) @(negedge i_clk);
    m.rbyte(1'b0, d);
    chk_byte("hold abort", 8'hFF, d);
    m.stop();
    i_hold = 1'b0;
    m.start();
    m.wbyte(8'hA1, k);
    chk_ack("pre rst ack", 1'b1, k);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    chk_ack("rst oe", 1'b0, sda_oe);
    chk_ack("rst out", 1'b0, sda_out);
    chk_ack("rst busy", 1'b0, busy);
    m.stop();
    i_rst = 1'b0;
    repeat (8) @(negedge i_clk);
    rd(1'b1, 8'hFF, 2);
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
